// >>> rtl/charge_ctrl_consts.vh
// constants for the charge cycle and mode controller
// assumes: included by the controller, its monitor and its bench, APB data 32 bits wide
`ifndef CHARGE_CTRL_CONSTS_VH
`define CHARGE_CTRL_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_LIM 12'h004
`define OFF_STAT 12'h008
// ----------------------------------------
// control register fields
// ----------------------------------------
`define C_CHG_EN 0
`define C_TERM_EN 1
`define C_PULSE_MODE_DISABLE 2
`define C_BOOST_EN 3
`define C_BOOST_CURRENT_SELECT 4
`define C_RECHG 5
`define C_WARM_V 6
`define C_COOL_I 7
`define C_STATF_LO 8
`define C_STATF_HI 9
`define C_WD_LO 10
`define C_WD_HI 11
`define C_TOP_LO 12
`define C_TOP_HI 13
`define C_WATCHDOG_RESTART_BIT 14
`define C_REG_RST 15
`define CTRL_W 14
`define CTRL_RST 14'h0403
// ----------------------------------------
// limit register fields
// ----------------------------------------
`define L_IIN_LO 0
`define L_IIN_HI 4
`define L_ICHG_LO 9
`define L_ICHG_HI 15
`define L_BDIS 18
`define LIM_W 19
`define LIM_RST 19'h1_40c5
`define LIM_KEEP 19'h7_01ff
// ----------------------------------------
// codes
// ----------------------------------------
`define IIN_STARTUP 5'h02
`define IIN_PFM_MIN 5'h05
`define IIN_USB 5'h05
`define SRC_NONE 3'h0
`define SRC_USB 3'h1
`define SRC_ADP 3'h3
`define SRC_BOOST 3'h7
`define PH_DIS 2'h0
`define PH_PRE 2'h1
`define PH_FAST 2'h2
`define PH_DONE 2'h3
`define CUR_SHORT 2'h0
`define CUR_PRE 2'h1
`define CUR_FAST 2'h2
`define STATF_OFF 2'h3
`define CODE_OFF 2'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define TW 26
// sized to the timer width so the products never get truncated
`define CLK_HZ 26'h17d_7840
`define MS_PER_S 26'h03e8
`define S_PER_MIN 26'h003c
`define S_PER_H 26'h0e10
`define T_BOOST_MS 26'h001e
`define T_SAFETY_H 26'h000a
`define T_WD_S 26'h0028
`define T_TOP_MIN 26'h000f
`define T_BLINK_MS 26'h01f4
`endif

// >>> rtl/charge_cycle_mode_control.v
// supervisory logic of a one-cell charger: start-up current cap,
// pulse-mode gating, boost qualification, watchdog modes, charge cycle
// assumes: APB master on pclk, analog levels already synchronous
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "charge_ctrl_consts.vh"
module charge_cycle_mode_control #(
   parameter [`TW-1:0] TICK_CYC = `CLK_HZ / `MS_PER_S,
   parameter [`TW-1:0] BOOST_CYC = `T_BOOST_MS * (`CLK_HZ / `MS_PER_S),
   parameter [`TW-1:0] SAFETY_MS = `T_SAFETY_H * `S_PER_H * `MS_PER_S,
   parameter [`TW-1:0] WD_MS = `T_WD_S * `MS_PER_S,
   parameter [`TW-1:0] TOP_MS = `T_TOP_MIN * `S_PER_MIN * `MS_PER_S,
   parameter [`TW-1:0] BLINK_MS = `T_BLINK_MS,
   parameter [4:0] IIN_ADAPTER = 5'h18
)(
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire [31:0] prdata,
   output wire pslverr,
   // device pins
   input wire source_select,
   input wire ce_n,
   output wire status_pin_out,
   output wire status_pin_oe,
   output wire int_pulse,
   // analog comparator levels
   input wire converter_on,
   input wire sys_below_2v2,
   input wire bat_below_2v2,
   input wire bat_below_3v,
   input wire bat_above_boost,
   input wire vbus_sleep,
   input wire ts_boost_ok,
   input wire ts_cold,
   input wire ts_cool,
   input wire ts_warm,
   input wire ts_hot,
   input wire chg_below_term,
   input wire bat_above_rechg_lo,
   input wire bat_above_rechg_hi,
   input wire in_current_reg,
   input wire in_voltage_reg,
   input wire thermal_reg,
   // converter controls
   output wire [4:0] input_current_limit,
   output wire pulse_mode_allowed,
   output wire boost_active,
   output wire boost_current_select,
   output wire charge_path_on,
   output wire [1:0] current_select,
   output wire cool_derate_half,
   output wire cool_derate_20pct,
   output wire warm_voltage_low
);
   localparam TW = `TW;
   localparam ST_IDLE = 2'h0;
   localparam ST_CHG = 2'h1;
   localparam ST_TOP = 2'h2;
   localparam ST_DONE = 2'h3;

   reg [`CTRL_W-1:0] ctrl_reg;
   reg [`LIM_W-1:0] lim_reg;
   reg [31:0] prdata_reg;
   reg host_mode_reg;
   reg psel_seen_reg;
   reg psel_prev_reg;
   reg [TW-1:0] tick_cnt_reg;
   reg [TW-1:0] wd_cnt_reg;
   reg [TW-1:0] boost_cnt_reg;
   reg [TW-1:0] safe_cnt_reg;
   reg [TW-1:0] top_cnt_reg;
   reg [TW-1:0] blink_cnt_reg;
   reg blink_reg;
   reg half_ph_reg;
   reg [1:0] state_reg;
   reg [1:0] top_len_reg;
   reg safety_fault_reg;
   reg chg_req_reg;
   reg int_reg;
   reg [4:0] iin_eff_reg;

   // wd periods double, top-off lengths step linearly
   function [TW-1:0] scale;
      input [1:0] code;
      input [TW-1:0] base;
      input pow2;
      begin
         case (code)
            2'h1: scale = base;
            2'h2: scale = base << 1;
            2'h3: scale = pow2 ? base << 2 : (base << 1) + base;
            default: scale = {TW{1'h0}};
         endcase
      end
   endfunction

   // ----------------------------------------
   // apb access
   // ----------------------------------------
   wire acc = psel & penable;
   wire hit_ctrl = paddr == `OFF_CTRL;
   wire hit_lim = paddr == `OFF_LIM;
   wire hit_stat = paddr == `OFF_STAT;
   wire wr_ctrl = acc & pwrite & hit_ctrl;
   wire wr_lim = acc & pwrite & hit_lim;
   wire watchdog_restart_bit_wr = wr_ctrl & pwdata[`C_WATCHDOG_RESTART_BIT];
   wire reg_rst_wr = wr_ctrl & pwdata[`C_REG_RST];
   assign pready = 1'h1;
   assign pslverr = acc & ~(hit_ctrl | hit_lim | hit_stat);
   assign prdata = prdata_reg;

   // ----------------------------------------
   // field views
   // ----------------------------------------
   wire [4:0] iin = lim_reg[`L_IIN_HI:`L_IIN_LO];
   wire [6:0] ichg = lim_reg[`L_ICHG_HI:`L_ICHG_LO];
   wire bdis = lim_reg[`L_BDIS];
   wire [1:0] wd_sel = ctrl_reg[`C_WD_HI:`C_WD_LO];
   wire [1:0] top_sel = ctrl_reg[`C_TOP_HI:`C_TOP_LO];
   wire [1:0] statf = ctrl_reg[`C_STATF_HI:`C_STATF_LO];

   // ----------------------------------------
   // time base and pacing
   // ----------------------------------------
   wire tick = tick_cnt_reg == TICK_CYC - 1'h1;
   wire regul = in_current_reg | in_voltage_reg | thermal_reg;
   wire ts_out = ts_cold | ts_hot;
   wire half = regul | ts_cool;
   wire slow_tick = tick & (~half | half_ph_reg);
   wire running = (state_reg == ST_CHG || state_reg == ST_TOP)
      & ~ts_out & converter_on;
   wire [TW-1:0] wd_lim = scale(wd_sel, WD_MS, 1'h1);
   wire [TW-1:0] top_lim = scale(top_len_reg, TOP_MS, 1'h0);

   // ----------------------------------------
   // charge decisions
   // ----------------------------------------
   wire chg_req = ctrl_reg[`C_CHG_EN] & ~ce_n;
   wire en_rise = chg_req & ~chg_req_reg;
   wire above_rechg = ctrl_reg[`C_RECHG] ? bat_above_rechg_hi
      : bat_above_rechg_lo;
   wire start_ok = converter_on & chg_req & (ichg != 7'h00) & ~ts_out
      & ~safety_fault_reg & ~bdis;
   wire stop = ~chg_req | bdis | ~converter_on;
   wire term = ctrl_reg[`C_TERM_EN] & chg_below_term & above_rechg
      & ~regul & ~ts_cool & ~ts_warm & ~ts_out;
   wire safe_exp = running & slow_tick
      & safe_cnt_reg == SAFETY_MS - 1'h1;
   wire top_exp = state_reg == ST_TOP & running & slow_tick
      & top_cnt_reg == top_lim - 1'h1;
   // a restart landing on the expiry edge keeps host mode
   wire wd_exp = host_mode_reg & wd_sel != `CODE_OFF & tick
      & wd_cnt_reg == wd_lim - 1'h1 & ~watchdog_restart_bit_wr;
   wire psel_load = ~host_mode_reg
      & (~psel_seen_reg | source_select != psel_prev_reg);

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign boost_active = ctrl_reg[`C_BOOST_EN] & bat_above_boost
      & vbus_sleep & ts_boost_ok & boost_cnt_reg == BOOST_CYC;
   assign boost_current_select = ctrl_reg[`C_BOOST_CURRENT_SELECT];
   assign pulse_mode_allowed = iin >= `IIN_PFM_MIN
      & ~ctrl_reg[`C_PULSE_MODE_DISABLE];
   assign input_current_limit = iin_eff_reg;
   assign charge_path_on = running;
   assign current_select = bat_below_2v2 ? `CUR_SHORT
      : bat_below_3v ? `CUR_PRE : `CUR_FAST;
   assign cool_derate_half = ts_cool & ~ctrl_reg[`C_COOL_I];
   assign cool_derate_20pct = ts_cool & ctrl_reg[`C_COOL_I];
   assign warm_voltage_low = ts_warm & ctrl_reg[`C_WARM_V];
   assign int_pulse = int_reg;

   wire startup_cap = converter_on & sys_below_2v2;
   wire [4:0] iin_next = (startup_cap & iin > `IIN_STARTUP)
      ? `IIN_STARTUP : iin;
   wire [2:0] src_stat = boost_active ? `SRC_BOOST
      : ~converter_on ? `SRC_NONE
      : source_select ? `SRC_USB : `SRC_ADP;
   wire [1:0] phase = state_reg == ST_IDLE ? `PH_DIS
      : state_reg == ST_CHG
      ? (current_select == `CUR_FAST ? `PH_FAST : `PH_PRE)
      : `PH_DONE;
   wire top_active = state_reg == ST_TOP;
   wire fault = safety_fault_reg | (state_reg != ST_IDLE & ts_out);
   assign status_pin_out = fault ? blink_reg
      : ~(state_reg == ST_CHG | state_reg == ST_TOP);
   assign status_pin_oe = statf != `STATF_OFF;
   wire [31:0] stat_word = {14'h0, iin_eff_reg, current_select,
      startup_cap, boost_active, pulse_mode_allowed, safety_fault_reg,
      top_active, ~host_mode_reg, src_stat, phase};

   // ----------------------------------------
   // registers and mode
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `CTRL_RST;
         lim_reg <= `LIM_RST;
         host_mode_reg <= 1'h0;
         psel_seen_reg <= 1'h0;
         psel_prev_reg <= 1'h0;
         wd_cnt_reg <= {TW{1'h0}};
         prdata_reg <= 32'h0000_0000;
         iin_eff_reg <= `IIN_STARTUP;
      end
      else
      begin
         iin_eff_reg <= iin_next;
         psel_seen_reg <= 1'h1;
         psel_prev_reg <= source_select;
         if (psel & ~penable)
         begin
            prdata_reg <= hit_ctrl ? {18'h0_0000, ctrl_reg}
               : hit_lim ? {13'h0000, lim_reg}
               : hit_stat ? stat_word : 32'h0000_0000;
         end
         if (watchdog_restart_bit_wr)
         begin
            host_mode_reg <= 1'h1;
            wd_cnt_reg <= {TW{1'h0}};
         end
         else if (wd_exp)
         begin
            host_mode_reg <= 1'h0;
            wd_cnt_reg <= {TW{1'h0}};
         end
         else if (host_mode_reg & wd_sel != `CODE_OFF & tick)
            wd_cnt_reg <= wd_cnt_reg + 1'h1;
         if (wd_exp | reg_rst_wr)
         begin
            ctrl_reg <= `CTRL_RST;
            lim_reg <= (lim_reg & `LIM_KEEP)
               | (`LIM_RST & ~`LIM_KEEP);
         end
         else
         begin
            if (wr_ctrl)
               ctrl_reg <= pwdata[`CTRL_W-1:0];
            if (wr_lim)
               lim_reg <= pwdata[`LIM_W-1:0];
         end
         // pin follows in default mode and beats a same-cycle write
         if (psel_load)
            lim_reg[`L_IIN_HI:`L_IIN_LO] <= source_select
               ? `IIN_USB : IIN_ADAPTER;
      end
   end

   // ----------------------------------------
   // timers
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_reg <= {TW{1'h0}};
         half_ph_reg <= 1'h0;
         boost_cnt_reg <= {TW{1'h0}};
         blink_cnt_reg <= {TW{1'h0}};
         blink_reg <= 1'h0;
         safe_cnt_reg <= {TW{1'h0}};
         top_cnt_reg <= {TW{1'h0}};
      end
      else
      begin
         tick_cnt_reg <= tick ? {TW{1'h0}} : tick_cnt_reg + 1'h1;
         if (tick)
            half_ph_reg <= ~half_ph_reg;
         if (~ctrl_reg[`C_BOOST_EN])
            boost_cnt_reg <= {TW{1'h0}};
         else if (boost_cnt_reg != BOOST_CYC)
            boost_cnt_reg <= boost_cnt_reg + 1'h1;
         if (tick)
         begin
            if (blink_cnt_reg == BLINK_MS - 1'h1)
            begin
               blink_cnt_reg <= {TW{1'h0}};
               blink_reg <= ~blink_reg;
            end
            else
               blink_cnt_reg <= blink_cnt_reg + 1'h1;
         end
         // a fresh cycle starts with a fresh timer
         if (state_reg == ST_IDLE | state_reg == ST_DONE)
            safe_cnt_reg <= {TW{1'h0}};
         else if (running & slow_tick)
            safe_cnt_reg <= safe_cnt_reg + 1'h1;
         if (state_reg != ST_TOP | en_rise | reg_rst_wr)
            top_cnt_reg <= {TW{1'h0}};
         else if (running & slow_tick)
            top_cnt_reg <= top_cnt_reg + 1'h1;
      end
   end

   // ----------------------------------------
   // charge cycle sequencer
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         top_len_reg <= `CODE_OFF;
         safety_fault_reg <= 1'h0;
         chg_req_reg <= 1'h0;
         int_reg <= 1'h0;
      end
      else
      begin
         int_reg <= 1'h0;
         chg_req_reg <= chg_req;
         // set wins over the clear by a dropped enable
         if (safe_exp)
            safety_fault_reg <= 1'h1;
         else if (~chg_req)
            safety_fault_reg <= 1'h0;
         case (state_reg)
            ST_IDLE:
            begin
               if (start_ok)
                  state_reg <= ST_CHG;
            end
            ST_CHG:
            begin
               if (stop | safe_exp)
               begin
                  state_reg <= ST_IDLE;
                  int_reg <= safe_exp;
               end
               else if (term)
               begin
                  int_reg <= 1'h1;
                  top_len_reg <= top_sel;
                  state_reg <= top_sel != `CODE_OFF ? ST_TOP : ST_DONE;
               end
            end
            ST_TOP:
            begin
               if (stop | safe_exp)
               begin
                  state_reg <= ST_IDLE;
                  int_reg <= safe_exp;
               end
               else if (top_exp)
               begin
                  state_reg <= ST_DONE;
                  int_reg <= 1'h1;
               end
            end
            ST_DONE:
            begin
               if (stop)
                  state_reg <= ST_IDLE;
               else if (~above_rechg & start_ok)
                  state_reg <= ST_CHG;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> dv/charge_cycle_mode_control_monitor.sv
// port assertions for the charge cycle and mode controller
// assumes: bound into the controller, one pclk domain
`timescale 1ns/1ps
`include "charge_ctrl_consts.vh"
module charge_mon (
   // bus
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire int_pulse,
   // levels
   input wire converter_on,
   input wire sys_below_2v2,
   input wire bat_below_2v2,
   input wire bat_below_3v,
   input wire bat_above_boost,
   input wire vbus_sleep,
   input wire ts_boost_ok,
   input wire ts_cold,
   input wire ts_cool,
   input wire ts_warm,
   input wire ts_hot,
   // controls
   input wire [4:0] input_current_limit,
   input wire pulse_mode_allowed,
   input wire boost_active,
   input wire charge_path_on,
   input wire [1:0] current_select,
   input wire cool_derate_half,
   input wire cool_derate_20pct,
   input wire warm_voltage_low
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_ZERO_WAIT: assert property (psel && penable |-> pready)
      else $error("access without ready");
   AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
      else $error("error flag outside access");
   AST_INT_ONE: assert property (int_pulse |=> !int_pulse)
      else $error("interrupt longer than a cycle");
   AST_START_CAP: assert property ((converter_on && sys_below_2v2)[*2]
      |-> input_current_limit <= `IIN_STARTUP) else $error("no start cap");
   // limit output lags the register by one edge, hence the past value;
   // the reset value of the limit flop breaks that lag at release
   AST_PFM_LOW: assert property ((presetn && !sys_below_2v2)[*2] ##0
      (input_current_limit < `IIN_PFM_MIN) |-> !$past(pulse_mode_allowed))
      else $error("pulse mode at low limit");
   AST_BOOST_GATE: assert property (boost_active |-> bat_above_boost
      && vbus_sleep && ts_boost_ok) else $error("boost without conditions");
   AST_TS_STOP: assert property ((ts_cold || ts_hot)[*2]
      |-> !charge_path_on) else $error("charging outside window");
   AST_COOL: assert property (cool_derate_half || cool_derate_20pct
      |-> ts_cool && !(cool_derate_half && cool_derate_20pct))
      else $error("cool derate wrong");
   AST_WARM: assert property (warm_voltage_low |-> ts_warm)
      else $error("warm voltage outside warm band");
   AST_SHORT: assert property (charge_path_on && bat_below_2v2
      |-> current_select == `CUR_SHORT) else $error("short current missed");
   AST_FAST: assert property (charge_path_on && !bat_below_3v
      |-> current_select == `CUR_FAST) else $error("fast current missed");
endmodule
bind charge_cycle_mode_control charge_mon u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .int_pulse(int_pulse),
   .converter_on(converter_on), .sys_below_2v2(sys_below_2v2),
   .bat_below_2v2(bat_below_2v2), .bat_below_3v(bat_below_3v),
   .bat_above_boost(bat_above_boost), .vbus_sleep(vbus_sleep),
   .ts_boost_ok(ts_boost_ok), .ts_cold(ts_cold), .ts_cool(ts_cool),
   .ts_warm(ts_warm), .ts_hot(ts_hot),
   .input_current_limit(input_current_limit),
   .pulse_mode_allowed(pulse_mode_allowed), .boost_active(boost_active),
   .charge_path_on(charge_path_on), .current_select(current_select),
   .cool_derate_half(cool_derate_half),
   .cool_derate_20pct(cool_derate_20pct),
   .warm_voltage_low(warm_voltage_low));

// >>> dv/apb_host.sv
// apb master standing in for the host processor
// assumes: pready sampled at rising edges, one transfer at a time
`timescale 1ns/1ps
module apb_host (
   // clock
   input wire pclk,
   // apb master
   output reg psel,
   output reg penable,
   output reg pwrite,
   output reg [11:0] paddr,
   output reg [31:0] pwdata,
   input wire pready
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // request held until ready is seen at a rising edge
   task xfer(input reg w, input reg [11:0] a, input reg [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
endmodule

// >>> dv/test_charge_cycle_mode_control.sv
// self-checking bench for the charge cycle and mode controller
// assumes: shortened timers, host model on the apb port
`timescale 1ns/1ps
`include "charge_ctrl_consts.vh"
module test_charge_cycle_mode_control;
   localparam [4:0] ADP = 5'h0c;
   reg pclk = 0, presetn = 0, source_select = 1, ce_n = 1;
   reg converter_on = 1, sys_below_2v2 = 0, bat_below_2v2 = 0;
   reg bat_below_3v = 0, bat_above_boost = 0, vbus_sleep = 0;
   reg ts_boost_ok = 1, ts_cold = 0, ts_cool = 0, ts_warm = 0;
   reg ts_hot = 0, chg_below_term = 0, bat_above_rechg_lo = 0;
   reg bat_above_rechg_hi = 0, in_current_reg = 0, in_voltage_reg = 0;
   reg thermal_reg = 0;
   wire psel, penable, pwrite, pready, pslverr, status_pin_out;
   wire status_pin_oe, int_pulse, pulse_mode_allowed, boost_active;
   wire boost_current_select, charge_path_on, cool_derate_half;
   wire cool_derate_20pct, warm_voltage_low;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [4:0] input_current_limit;
   wire [1:0] current_select;
   integer errors = 0, cmp_count = 0, cyc = 0, i;
   reg [31:0] seed = 32'h2dfb_5e87;
   reg [64:0] exp_q[$];
   reg [64:0] e;
   reg p;
   initial
      forever #20 pclk = ~pclk;
   charge_cycle_mode_control #(.TICK_CYC(26'h0004), .BOOST_CYC(26'h0014),
      .SAFETY_MS(26'h0032), .WD_MS(26'h000a), .TOP_MS(26'h0005),
      .BLINK_MS(26'h0002),
      .IIN_ADAPTER(ADP)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .source_select(source_select),
      .ce_n(ce_n), .status_pin_out(status_pin_out),
      .status_pin_oe(status_pin_oe), .int_pulse(int_pulse),
      .converter_on(converter_on), .sys_below_2v2(sys_below_2v2),
      .bat_below_2v2(bat_below_2v2), .bat_below_3v(bat_below_3v),
      .bat_above_boost(bat_above_boost), .vbus_sleep(vbus_sleep),
      .ts_boost_ok(ts_boost_ok), .ts_cold(ts_cold), .ts_cool(ts_cool),
      .ts_warm(ts_warm), .ts_hot(ts_hot), .chg_below_term(chg_below_term),
      .bat_above_rechg_lo(bat_above_rechg_lo),
      .bat_above_rechg_hi(bat_above_rechg_hi),
      .in_current_reg(in_current_reg), .in_voltage_reg(in_voltage_reg),
      .thermal_reg(thermal_reg), .input_current_limit(input_current_limit),
      .pulse_mode_allowed(pulse_mode_allowed), .boost_active(boost_active),
      .boost_current_select(boost_current_select),
      .charge_path_on(charge_path_on), .current_select(current_select),
      .cool_derate_half(cool_derate_half),
      .cool_derate_20pct(cool_derate_20pct),
      .warm_voltage_low(warm_voltage_low));
   apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   task chk(input reg [31:0] a, input reg [31:0] x);
   begin
      cmp_count = cmp_count + 1;
      if (a !== x)
      begin
         errors = errors + 1;
         $display("Error at %0t: got %h expected %h", $time, a, x);
      end
   end
   endtask
   // ----------------------------------------
   // bus helpers and read watcher
   // ----------------------------------------
   task rd(input reg [11:0] a, input reg [31:0] m, input reg [31:0] v);
   begin
      exp_q.push_back({a > `OFF_STAT, m, v});
      u_host.xfer(1'b0, a, 32'h0000_0000);
   end
   endtask
   task wr(input reg [11:0] a, input reg [31:0] d);
      u_host.xfer(1'b1, a, d);
   endtask
   // settle on a falling edge so outputs are stable when compared
   task w(input integer n);
   begin
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   end
   endtask
   task wint(input integer lim);
      integer n;
   begin
      n = 0;
      @(negedge pclk);
      while (int_pulse !== 1'b1 && n < lim)
      begin
         @(negedge pclk);
         n = n + 1;
      end
      chk(int_pulse, 1);
   end
   endtask
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
      begin
         e = exp_q.pop_front();
         chk({31'h0, pslverr}, {31'h0, e[64]});
         chk(prdata & e[63:32], e[31:0]);
      end
   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         errors = errors + 1;
         conclude;
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFF_CTRL, 32'hffff_ffff, 32'h0000_0403);
      rd(`OFF_LIM, 32'hffff_ffff, 32'h0001_40c5);
      rd(`OFF_STAT, 32'h0000_0020, 32'h0000_0020);
      seed = xs(seed);
      rd((seed[11:0] | 12'h00c) & 12'hffc, 32'hffff_ffff, 32'h0);
      source_select <= 1'b0;
      w(3);
      rd(`OFF_LIM, 32'h0000_001f, {27'h0, ADP});
      source_select <= 1'b1;
      sys_below_2v2 <= 1'b1;
      w(3);
      chk(input_current_limit, `IIN_STARTUP);
      @(posedge pclk);
      sys_below_2v2 <= 1'b0;
      w(3);
      chk(input_current_limit, `IIN_USB);
      $display("test reset and source pin done");
      wr(`OFF_CTRL, 32'h0000_4003);
      rd(`OFF_STAT, 32'h0000_0020, 32'h0);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(`OFF_LIM, 32'h0001_40c4 | i[0]);
         wr(`OFF_CTRL, 32'h0000_0003 | (i[1] << 2));
         w(2);
         chk(pulse_mode_allowed, i == 1);
      end
      seed = xs(seed);
      wr(`OFF_LIM, seed & 32'h0007_ffff);
      rd(`OFF_LIM, 32'hffff_ffff, seed & 32'h0007_ffff);
      $display("test pulse mode and limits done");
      wr(`OFF_LIM, 32'h0003_00a7);
      wr(`OFF_CTRL, 32'h0000_4403);
      repeat (3)
      begin
         repeat (25) @(posedge pclk);
         wr(`OFF_CTRL, 32'h0000_4403);
      end
      rd(`OFF_STAT, 32'h0000_0020, 32'h0);
      repeat (60) @(posedge pclk);
      rd(`OFF_STAT, 32'h0000_0020, 32'h0000_0020);
      rd(`OFF_CTRL, 32'hffff_ffff, 32'h0000_0403);
      rd(`OFF_LIM, 32'hffff_ffff, (32'h0003_00a7 & `LIM_KEEP)
         | (`LIM_RST & ~`LIM_KEEP));
      $display("test watchdog done");
      w(3);
      chk(charge_path_on, 0);
      chk(status_pin_out, 1);
      @(posedge pclk);
      bat_below_2v2 <= 1'b1;
      bat_below_3v <= 1'b1;
      ce_n <= 1'b0;
      w(3);
      chk(status_pin_out, 0);
      rd(`OFF_STAT, 32'h0000_0003, `PH_PRE);
      bat_below_2v2 <= 1'b0;
      w(2);
      chk(current_select, `CUR_PRE);
      rd(`OFF_STAT, 32'h0000_0003, `PH_PRE);
      bat_below_3v <= 1'b0;
      chg_below_term <= 1'b1;
      bat_above_rechg_lo <= 1'b1;
      in_current_reg <= 1'b1;
      w(20);
      chk(charge_path_on, 1);
      @(posedge pclk);
      in_current_reg <= 1'b0;
      wint(10);
      rd(`OFF_STAT, 32'h0000_0003, `PH_DONE);
      w(1);
      chk(charge_path_on, 0);
      chk(status_pin_out, 1);
      @(posedge pclk);
      bat_above_rechg_lo <= 1'b0;
      chg_below_term <= 1'b0;
      rd(`OFF_STAT, 32'h0000_0003, `PH_FAST);
      wint(450);
      w(1);
      chk(charge_path_on, 0);
      p = status_pin_out;
      w(8);
      chk(status_pin_out, !p);
      @(posedge pclk);
      ce_n <= 1'b1;
      w(2);
      chk(status_pin_out, 1);
      $display("test default charge cycle done");
      wr(`OFF_CTRL, 32'h0000_5303);
      chg_below_term <= 1'b1;
      bat_above_rechg_lo <= 1'b1;
      ce_n <= 1'b0;
      wint(20);
      rd(`OFF_STAT, 32'h0000_0043, 32'h0000_0043);
      wint(60);
      w(2);
      chk(charge_path_on, 0);
      chk(status_pin_oe, 0);
      rd(`OFF_STAT, 32'h0000_0043, 32'h0000_0003);
      $display("test top-off done");
      bat_above_rechg_lo <= 1'b0;
      chg_below_term <= 1'b0;
      ts_cool <= 1'b1;
      w(3);
      chk(charge_path_on, 1);
      chk(cool_derate_half | cool_derate_20pct, 1);
      @(posedge pclk);
      ts_cool <= 1'b0;
      ts_warm <= 1'b1;
      wr(`OFF_CTRL, 32'h0000_1343);
      w(2);
      chk(warm_voltage_low, 1);
      @(posedge pclk);
      ts_warm <= 1'b0;
      ts_hot <= 1'b1;
      w(3);
      chk(charge_path_on, 0);
      @(posedge pclk);
      ts_hot <= 1'b0;
      ts_cold <= 1'b1;
      w(3);
      chk(charge_path_on, 0);
      $display("test thermistor done");
      @(posedge pclk);
      ts_cold <= 1'b0;
      bat_above_boost <= 1'b1;
      vbus_sleep <= 1'b1;
      wr(`OFF_CTRL, 32'h0000_4018);
      w(10);
      chk(boost_active, 0);
      w(15);
      chk(boost_active, 1);
      chk(boost_current_select, 1);
      rd(`OFF_STAT, 32'h0000_001c, {`SRC_BOOST, 2'b00});
      bat_above_boost <= 1'b0;
      w(2);
      chk(boost_active, 0);
      $display("test boost done");
      conclude;
   end
endmodule
